// File: design/tdis_pkg.sv
// Constants for the table and DAC input select block.
// Assumes byte addresses of nine bits, as the tables reach past FFh.
package tdis_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [8:0] TDIS_ADDR_CTRL0 = 9'h080;
	localparam logic [8:0] TDIS_ADDR_CTRL1 = 9'h081;
	localparam logic [8:0] TDIS_ADDR_CTRL2 = 9'h082;
	localparam logic [8:0] TDIS_ADDR_CTRL3 = 9'h083;
	localparam logic [8:0] TDIS_ADDR_CTRL4 = 9'h084;
	localparam logic [8:0] TDIS_ADDR_CTRL5 = 9'h085;
	localparam logic [8:0] TDIS_ADDR_WGATE = 9'h086;
	localparam logic [8:0] TDIS_ADDR_STATUS = 9'h087;
	localparam logic [8:0] TDIS_FIRST_TABLE_BASE = 9'h090;
	localparam logic [8:0] TDIS_SECOND_TABLE_BASE = 9'h0D0;
	localparam logic [8:0] TDIS_LUT_END = 9'h10F;
	localparam int TDIS_LUT_ROWS = 64;
	localparam int TDIS_CTRL_REGS = 6;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	// Control register 0
	localparam int TDIS_GEN1_DIR_BIT = 7;
	localparam int TDIS_GEN2_DIR_BIT = 6;
	localparam int TDIS_REF_SEL_BIT = 5;
	localparam int TDIS_IN_SEL_BIT = 4;
	localparam int TDIS_FILT_OFF_BIT = 3;
	// Control register 5
	localparam int TDIS_TBL1_DIR_BIT = 4;
	localparam int TDIS_DAC1_DIR_BIT = 5;
	localparam int TDIS_TBL2_DIR_BIT = 6;
	localparam int TDIS_DAC2_DIR_BIT = 7;
	// Write-gate and status registers
	localparam int TDIS_WGATE_BIT = 7;
	localparam int TDIS_RESULT_LSB = 2;

	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	localparam logic [7:0] TDIS_WGATE_SET = 8'h80;
	localparam logic [7:0] TDIS_WGATE_CLR = 8'h00;
	localparam logic [7:0] TDIS_CTRL_RESET = 8'h00;
	localparam logic [7:0] TDIS_DAC_IDLE = 8'h00;
	localparam logic [2:0] TDIS_MATCH_NEEDED = 3'h4;

endpackage

// File: design/tdis_conv_filter.sv
// Conversion filter: decides when a new converter code becomes the result.
// Assumes conversions arrive as one-cycle strobes from same-clock logic.
`timescale 1ns/1ps
module tdis_conv_filter
	import tdis_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic convValid,
	input wire logic [5:0] convCode,
	input wire logic filterOff,
	output logic [5:0] result_q,
	output logic resultValid_q
);

	// ----------------------------------------------------------------
	// Run counter
	// ----------------------------------------------------------------
	logic [5:0] prevCode_q;
	logic havePrev_q;
	logic [2:0] runCnt_q;
	logic [2:0] runCnt_d;
	logic sameCode;
	logic takeCode;

	// A differing code starts a new run of one
	assign sameCode = havePrev_q && (convCode == prevCode_q);
	assign runCnt_d = !sameCode ? 3'h1 :
		(runCnt_q >= TDIS_MATCH_NEEDED) ? runCnt_q : runCnt_q + 3'h1;
	// Filter off passes every code; on, only a run of four
	assign takeCode = convValid &&
		(filterOff || runCnt_d >= TDIS_MATCH_NEEDED);

	// Run tracking
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prevCode_q <= 6'h00;
			havePrev_q <= 1'b0;
			runCnt_q <= 3'h0;
		end else if (convValid) begin
			prevCode_q <= convCode;
			havePrev_q <= 1'b1;
			runCnt_q <= runCnt_d;
		end
	end

	// Result register, straight binary code
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			result_q <= 6'h00;
			resultValid_q <= 1'b0;
		end else if (takeCode) begin
			result_q <= convCode;
			resultValid_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	filterBypass_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		convValid && filterOff |=> result_q == $past(convCode))
		else $error("unfiltered code not taken");

	runRestart_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		convValid && !filterOff && havePrev_q && convCode != prevCode_q
		|=> $stable(result_q) && runCnt_q == 3'h1)
		else $error("differing code did not restart the run");

endmodule // tdis_conv_filter

// File: design/tdis_table_dac_input_select.sv
// Digital control path of a dual current-generator controller:
// control registers, write gate, table memory and DAC input selection.
// Assumes a serial front end that presents one byte access per strobe
// on the clk domain; converter codes arrive from same-clock logic.
//
// Summary of operation
// - DAC1 takes table1 row or control byte 3
// - Table2 row from converter or direct bits
// - DAC2 takes table2 row or control byte 4
// - Writes other than to the gate refused and unacknowledged while gate clear
// - Gate latch: 80h sets, 00h clears, else holds
// - Gate write leaves other gate bits unchanged
// - Address 87h reads converter result, read-only
// - Result is six-bit straight binary code
// - Filter needs four equal conversions unless off
// - Reference select: 0 internal, 1 external
// - Converter input: 0 sensor, 1 sense pin
// - Row address is table base plus row
// - Direct row bits from control registers 1, 2
// - Three DAC sources: converter, direct row, byte
// - Separate direction bits for both generators
// - Table1 row from converter or direct bits
// - Generator two: 0 source, 1 sink
// - DAC bytes zero until first valid result when fed from a converter-driven row
`timescale 1ns/1ps
module tdis_table_dac_input_select
	import tdis_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic memWrEn,
	input wire logic memRdEn,
	input wire logic [8:0] memAddr,
	input wire logic [7:0] memWrData,
	output logic [7:0] memRdData_q,
	output logic writeAck_q,
	input wire logic convValid,
	input wire logic [5:0] convCode,
	output logic [7:0] dac1Byte_q,
	output logic [7:0] dac2Byte_q,
	output logic [8:0] table1Addr_q,
	output logic [8:0] table2Addr_q,
	output logic refExternal_q,
	output logic senseExternal_q,
	output logic gen1Sink_q,
	output logic gen2Sink_q,
	output logic writeGate_q
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte address of a table row
	function automatic logic [8:0] rowAddr(input logic [8:0] base,
		input logic [5:0] row);
		rowAddr = base + {3'h0, row};
	endfunction

	// Address lies in [lo, hi]
	function automatic logic inRange(input logic [8:0] addr,
		input logic [8:0] lo, input logic [8:0] hi);
		inRange = (addr >= lo) && (addr <= hi);
	endfunction

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] ctrl_q [0:TDIS_CTRL_REGS-1];
	logic [7:0] lut_q [0:2*TDIS_LUT_ROWS-1];
	logic [5:0] result;
	logic resultValid;

	// Conversion filter
	tdis_conv_filter u_filter (
		.clk(clk),
		.reset_n(reset_n),
		.convValid(convValid),
		.convCode(convCode),
		.filterOff(ctrl_q[0][TDIS_FILT_OFF_BIT]),
		.result_q(result),
		.resultValid_q(resultValid)
	);

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	logic hitGate;
	logic hitStatus;
	logic hitCtrl;
	logic hitLut;
	logic writeAllowed;
	logic [2:0] ctrlIdx;
	logic [6:0] lutIdx;

	assign hitGate = memAddr == TDIS_ADDR_WGATE;
	assign hitStatus = memAddr == TDIS_ADDR_STATUS;
	assign hitCtrl = inRange(memAddr, TDIS_ADDR_CTRL0, TDIS_ADDR_CTRL5);
	assign hitLut = inRange(memAddr, TDIS_FIRST_TABLE_BASE, TDIS_LUT_END);
	assign ctrlIdx = memAddr[2:0];
	assign lutIdx = 7'(memAddr - TDIS_FIRST_TABLE_BASE);
	// The gate register is always reachable, else it could never open
	assign writeAllowed = writeGate_q || hitGate;

	// ----------------------------------------------------------------
	// Write gate latch
	// ----------------------------------------------------------------
	// Only the two exact patterns act; reserved bits stay zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			writeGate_q <= 1'b0;
		end else if (memWrEn && hitGate) begin
			if (memWrData == TDIS_WGATE_SET) begin
				writeGate_q <= 1'b1;
			end else if (memWrData == TDIS_WGATE_CLR) begin
				writeGate_q <= 1'b0;
			end
		end
	end

	// Acknowledge of the data byte, one cycle after the strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			writeAck_q <= 1'b0;
		end else begin
			writeAck_q <= memWrEn && writeAllowed;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Volatile copies; recall from nonvolatile store is outside this block
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < TDIS_CTRL_REGS; i++) begin
				ctrl_q[i] <= TDIS_CTRL_RESET;
			end
		end else if (memWrEn && hitCtrl && writeGate_q) begin
			ctrl_q[ctrlIdx] <= memWrData;
		end
	end

	// Table memory; no reset, it models nonvolatile cells
	always_ff @(posedge clk) begin
		if (memWrEn && hitLut && writeGate_q) begin
			lut_q[lutIdx] <= memWrData;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] readMux;
	logic [7:0] statusByte;
	logic [7:0] gateByte;

	assign statusByte = {result, 2'b00};
	assign gateByte = {writeGate_q, 7'h00};
	// Reserved locations read as zero
	assign readMux = hitCtrl ? ctrl_q[ctrlIdx] :
		hitGate ? gateByte :
		hitStatus ? statusByte :
		hitLut ? lut_q[lutIdx] : 8'h00;

	// Read data register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			memRdData_q <= 8'h00;
		end else if (memRdEn) begin
			memRdData_q <= readMux;
		end
	end

	// ----------------------------------------------------------------
	// Row and DAC source selection
	// ----------------------------------------------------------------
	logic tbl1Direct;
	logic tbl2Direct;
	logic dac1Direct;
	logic dac2Direct;
	logic [5:0] row1;
	logic [5:0] row2;
	logic [7:0] tbl1Byte;
	logic [7:0] tbl2Byte;
	logic [7:0] dac1Byte_d;
	logic [7:0] dac2Byte_d;
	logic rowReady1;
	logic rowReady2;

	assign tbl1Direct = ctrl_q[5][TDIS_TBL1_DIR_BIT];
	assign tbl2Direct = ctrl_q[5][TDIS_TBL2_DIR_BIT];
	assign dac1Direct = ctrl_q[5][TDIS_DAC1_DIR_BIT];
	assign dac2Direct = ctrl_q[5][TDIS_DAC2_DIR_BIT];
	// Direct rows from the six low bits of registers 1 and 2
	assign row1 = tbl1Direct ? ctrl_q[1][5:0] : result;
	assign row2 = tbl2Direct ? ctrl_q[2][5:0] : result;
	assign tbl1Byte = lut_q[{1'b0, row1}];
	assign tbl2Byte = lut_q[{1'b1, row2}];
	// A converter-driven row is meaningless before the first result
	assign rowReady1 = tbl1Direct || resultValid;
	assign rowReady2 = tbl2Direct || resultValid;
	// Direct byte bypasses converter and table alike
	assign dac1Byte_d = dac1Direct ? ctrl_q[3] :
		rowReady1 ? tbl1Byte : TDIS_DAC_IDLE;
	assign dac2Byte_d = dac2Direct ? ctrl_q[4] :
		rowReady2 ? tbl2Byte : TDIS_DAC_IDLE;

	// DAC input and row address registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dac1Byte_q <= TDIS_DAC_IDLE;
			dac2Byte_q <= TDIS_DAC_IDLE;
			table1Addr_q <= TDIS_FIRST_TABLE_BASE;
			table2Addr_q <= TDIS_SECOND_TABLE_BASE;
		end else begin
			dac1Byte_q <= dac1Byte_d;
			dac2Byte_q <= dac2Byte_d;
			table1Addr_q <= rowAddr(TDIS_FIRST_TABLE_BASE, row1);
			table2Addr_q <= rowAddr(TDIS_SECOND_TABLE_BASE, row2);
		end
	end

	// ----------------------------------------------------------------
	// Analog selects and directions
	// ----------------------------------------------------------------
	// Registered so every output leaves from a flip-flop
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			refExternal_q <= 1'b0;
			senseExternal_q <= 1'b0;
			gen1Sink_q <= 1'b0;
			gen2Sink_q <= 1'b0;
		end else begin
			refExternal_q <= ctrl_q[0][TDIS_REF_SEL_BIT];
			senseExternal_q <= ctrl_q[0][TDIS_IN_SEL_BIT];
			gen1Sink_q <= ctrl_q[0][TDIS_GEN1_DIR_BIT];
			gen2Sink_q <= ctrl_q[0][TDIS_GEN2_DIR_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	dacOneDirect_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		dac1Direct |=> dac1Byte_q == $past(ctrl_q[3]))
		else $error("DAC1 direct byte not applied");

	dacTwoDirect_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		dac2Direct |=> dac2Byte_q == $past(ctrl_q[4]))
		else $error("DAC2 direct byte not applied");

	tableTwoRow_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		!tbl2Direct |=> table2Addr_q == 9'(TDIS_SECOND_TABLE_BASE + $past(result)))
		else $error("table2 row not taken from result");

	tableOneRow_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		tbl1Direct |=>
		table1Addr_q == 9'(TDIS_FIRST_TABLE_BASE + $past(ctrl_q[1][5:0])))
		else $error("table1 direct row not applied");

	gatedNoAck_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		memWrEn && !writeGate_q && !hitGate |=> !writeAck_q)
		else $error("write acknowledged with gate clear");

	gateSet_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		memWrEn && hitGate && memWrData == TDIS_WGATE_SET
		|=> writeGate_q && writeAck_q)
		else $error("gate latch did not set");

	gateHold_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		!(memWrEn && hitGate && (memWrData == TDIS_WGATE_SET ||
		memWrData == TDIS_WGATE_CLR)) |=> $stable(writeGate_q))
		else $error("gate latch changed without a pattern");

	statusRead_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		memRdEn && hitStatus |=>
		memRdData_q[7:2] == $past(result) && memRdData_q[1:0] == 2'b00)
		else $error("status read mismatch");

	dacIdle_a : assert property (
		@(posedge clk) disable iff (!reset_n)
		!resultValid && !dac1Direct && !tbl1Direct
		|=> dac1Byte_q == TDIS_DAC_IDLE)
		else $error("DAC1 not idle before first result");

endmodule // tdis_table_dac_input_select

// File: verif/tdis_host_model.sv
// Host model: issues single-byte register accesses on the strobe port.
// Assumes it shares clk with the device and drives on the falling edge.
`timescale 1ns/1ps
module tdis_host_model (
	input wire logic clk,
	output logic memWrEn,
	output logic memRdEn,
	output logic [8:0] memAddr,
	output logic [7:0] memWrData,
	input wire logic [7:0] memRdData_q,
	input wire logic writeAck_q
);
	// ------------------------------------------------------------
	// Idle state
	// ------------------------------------------------------------
	// Strobes low from time zero
	initial begin
		memWrEn = 1'b0;
		memRdEn = 1'b0;
		memAddr = 9'h000;
		memWrData = 8'h00;
	end

	// ------------------------------------------------------------
	// Accesses
	// ------------------------------------------------------------
	// One byte write; ack is sampled the cycle after the strobe
	task automatic wr(input logic [8:0] a, input logic [7:0] d,
		output logic ack);
		@(negedge clk);
		memWrEn = 1'b1;
		memAddr = a;
		memWrData = d;
		@(posedge clk);
		@(negedge clk);
		ack = writeAck_q;
		memWrEn = 1'b0;
		memAddr = ~a; // Released lines never keep the old value
		memWrData = ~d;
	endtask

	// One byte read; data registered one cycle after the strobe
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(negedge clk);
		memRdEn = 1'b1;
		memAddr = a;
		@(posedge clk);
		@(negedge clk);
		d = memRdData_q;
		memRdEn = 1'b0;
		memAddr = ~a;
	endtask
endmodule // tdis_host_model

// File: verif/tb_table_dac_input_select.sv
// Self-checking bench for the table and DAC input select block.
// Assumes the host model drives the register port; bench drives converter.
`timescale 1ns/1ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
	nMismatch++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_table_dac_input_select;
	import tdis_pkg::*;
	typedef struct packed {
		logic [7:0] c0, c5, r1, r2, b3, b4, d1, d2;
		logic [8:0] t1, t2;
	} tdis_row_s;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic convValid = 1'b0;
	logic [5:0] convCode = 6'h00;
	logic memWrEn, memRdEn, writeAck_q;
	logic [8:0] memAddr, table1Addr_q, table2Addr_q;
	logic [7:0] memWrData, memRdData_q, dac1Byte_q, dac2Byte_q;
	logic refExternal_q, senseExternal_q, gen1Sink_q, gen2Sink_q;
	logic writeGate_q;
	int nMismatch = 0;
	int samplesChecked = 0;
	tdis_row_s rows [6] = '{
		'{8'h08, 8'h00, 8'hFF, 8'h7F, 8'hC3, 8'h3C, 8'h55, 8'h95, 9'h0A5, 9'h0E5},
		'{8'h88, 8'h10, 8'hFF, 8'h7F, 8'hC3, 8'h3C, 8'h7F, 8'h95, 9'h0CF, 9'h0E5},
		'{8'h48, 8'h40, 8'hC0, 8'hFF, 8'hC3, 8'h3C, 8'h55, 8'hBF, 9'h0A5, 9'h10F},
		'{8'h28, 8'h20, 8'hFF, 8'hFF, 8'hC3, 8'h3C, 8'hC3, 8'h95, 9'h0A5, 9'h0E5},
		'{8'h18, 8'h80, 8'hFF, 8'hFF, 8'hC3, 8'h3C, 8'h55, 8'h3C, 9'h0A5, 9'h0E5},
		'{8'hF8, 8'hF0, 8'h3F, 8'h3F, 8'hC3, 8'h3C, 8'hC3, 8'h3C, 9'h0CF, 9'h10F}};
	logic [5:0] lutRows [4] = '{6'h00, 6'h15, 6'h2A, 6'h3F};

	// ------------------------------------------------------------
	// Clock, device and host
	// ------------------------------------------------------------
	// 25 MHz clock
	always #20 clk = ~clk;

	tdis_table_dac_input_select dut (.clk(clk), .reset_n(reset_n),
		.memWrEn(memWrEn), .memRdEn(memRdEn), .memAddr(memAddr),
		.memWrData(memWrData), .memRdData_q(memRdData_q),
		.writeAck_q(writeAck_q), .convValid(convValid),
		.convCode(convCode), .dac1Byte_q(dac1Byte_q),
		.dac2Byte_q(dac2Byte_q), .table1Addr_q(table1Addr_q),
		.table2Addr_q(table2Addr_q), .refExternal_q(refExternal_q),
		.senseExternal_q(senseExternal_q), .gen1Sink_q(gen1Sink_q),
		.gen2Sink_q(gen2Sink_q), .writeGate_q(writeGate_q));

	tdis_host_model host (.clk(clk), .memWrEn(memWrEn),
		.memRdEn(memRdEn), .memAddr(memAddr), .memWrData(memWrData),
		.memRdData_q(memRdData_q), .writeAck_q(writeAck_q));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Write and check the acknowledge
	task automatic wrc(input logic [8:0] a, input logic [7:0] d,
		input logic e);
		logic ack;
		host.wr(a, d, ack);
		`CHK(ack, e)
	endtask

	// Read and check the data
	task automatic rdc(input logic [8:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		`CHK(d, e)
	endtask

	// One conversion strobe; code line scrambled afterwards
	task automatic conv(input logic [5:0] c);
		@(negedge clk);
		convValid = 1'b1;
		convCode = c;
		@(negedge clk);
		convValid = 1'b0;
		convCode = ~c;
	endtask

	// Reset held for ten cycles, then power-up values checked
	task automatic doReset;
		reset_n = 1'b0;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		`CHK(writeGate_q, 1'b0)
		`CHK(dac1Byte_q, TDIS_DAC_IDLE)
		`CHK(dac2Byte_q, TDIS_DAC_IDLE)
		`CHK({refExternal_q, senseExternal_q}, 2'b00)
		`CHK({gen1Sink_q, gen2Sink_q}, 2'b00)
		`CHK(table1Addr_q, TDIS_FIRST_TABLE_BASE)
	endtask

	task automatic give_verdict;
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	// Watchdog well beyond the expected run of about two hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		give_verdict();
	end

	// Main sequence: gate, filter, source table, then awkward cases
	initial begin
		doReset();
		wrc(TDIS_ADDR_CTRL1, 8'h3F, 1'b0);
		rdc(TDIS_ADDR_CTRL1, 8'h00);
		wrc(TDIS_ADDR_WGATE, TDIS_WGATE_SET, 1'b1);
		`CHK(writeGate_q, 1'b1)
		wrc(TDIS_ADDR_WGATE, 8'h7F, 1'b1);
		rdc(TDIS_ADDR_WGATE, 8'h80);
		foreach (lutRows[i]) begin
			wrc(TDIS_FIRST_TABLE_BASE + 9'(lutRows[i]), {2'b01, lutRows[i]}, 1'b1);
			wrc(TDIS_SECOND_TABLE_BASE + 9'(lutRows[i]), {2'b10, lutRows[i]}, 1'b1);
		end
		`CHK(dac1Byte_q, 8'h00)
		// Three equal, a break, then three equal: still no result
		for (int i = 0; i < 7; i++) conv(i == 3 ? 6'h15 : 6'h2A);
		repeat (3) @(negedge clk);
		rdc(TDIS_ADDR_STATUS, 8'h00);
		`CHK(dac2Byte_q, 8'h00)
		conv(6'h2A);
		repeat (3) @(negedge clk);
		rdc(TDIS_ADDR_STATUS, 8'hA8);
		`CHK(dac1Byte_q, 8'h6A)
		`CHK(dac2Byte_q, 8'hAA)
		`CHK(table2Addr_q, 9'h0FA)
		wrc(TDIS_ADDR_STATUS, 8'hFF, 1'b1);
		rdc(TDIS_ADDR_STATUS, 8'hA8);
		wrc(TDIS_ADDR_CTRL0, 8'h08, 1'b1);
		conv(6'h3F);
		rdc(TDIS_ADDR_STATUS, 8'hFC);
		conv(6'h15);
		rdc(TDIS_ADDR_STATUS, 8'h54);
		foreach (rows[i]) begin
			wrc(TDIS_ADDR_CTRL0, rows[i].c0, 1'b1);
			wrc(TDIS_ADDR_CTRL5, rows[i].c5, 1'b1);
			wrc(TDIS_ADDR_CTRL1, rows[i].r1, 1'b1);
			wrc(TDIS_ADDR_CTRL2, rows[i].r2, 1'b1);
			wrc(TDIS_ADDR_CTRL3, rows[i].b3, 1'b1);
			wrc(TDIS_ADDR_CTRL4, rows[i].b4, 1'b1);
			repeat (2) @(negedge clk);
			`CHK(dac1Byte_q, rows[i].d1)
			`CHK(dac2Byte_q, rows[i].d2)
			`CHK(table1Addr_q, rows[i].t1)
			`CHK(table2Addr_q, rows[i].t2)
			`CHK(refExternal_q, rows[i].c0[TDIS_REF_SEL_BIT])
			`CHK(senseExternal_q, rows[i].c0[TDIS_IN_SEL_BIT])
			`CHK(gen1Sink_q, rows[i].c0[TDIS_GEN1_DIR_BIT])
			`CHK(gen2Sink_q, rows[i].c0[TDIS_GEN2_DIR_BIT])
		end
		wrc(TDIS_ADDR_WGATE, TDIS_WGATE_CLR, 1'b1);
		`CHK(writeGate_q, 1'b0)
		wrc(TDIS_ADDR_CTRL3, 8'h11, 1'b0);
		rdc(TDIS_ADDR_CTRL3, 8'hC3);
		rdc(9'h088, 8'h00);
		doReset();
		give_verdict();
	end
endmodule // tb_table_dac_input_select
